//--- common/kcr_pkg.sv
// constants and types shared by the keyboard command responder
package kcr_pkg;
  // host commands
  localparam logic [7:0] CMD_SET_LEDS  = 8'hed;
  localparam logic [7:0] CMD_ECHO      = 8'hee;
  localparam logic [7:0] CMD_BAD_A     = 8'hef;
  localparam logic [7:0] CMD_SCAN_SET  = 8'hf0;
  localparam logic [7:0] CMD_BAD_B     = 8'hf1;
  localparam logic [7:0] CMD_READ_ID   = 8'hf2;
  localparam logic [7:0] CMD_RATE      = 8'hf3;
  localparam logic [7:0] CMD_ENABLE    = 8'hf4;
  localparam logic [7:0] CMD_DEF_DIS   = 8'hf5;
  localparam logic [7:0] CMD_SET_DEF   = 8'hf6;
  localparam logic [7:0] CMD_ALL_LAST  = 8'hfa;
  localparam logic [7:0] CMD_TYPE_LAST = 8'hfd;
  localparam logic [7:0] CMD_RESEND    = 8'hfe;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  // keyboard answers and scan bytes
  localparam logic [7:0] RSP_ACK       = 8'hfa;
  localparam logic [7:0] RSP_POST_OK   = 8'haa;
  localparam logic [7:0] RSP_POST_FAIL = 8'hfc;
  localparam logic [7:0] RSP_ECHO      = 8'hee;
  localparam logic [7:0] RSP_RESEND    = 8'hfe;
  localparam logic [7:0] ERR_SET1      = 8'hff;
  localparam logic [7:0] ERR_SET23     = 8'h00;
  localparam logic [7:0] BREAK_PREFIX  = 8'hf0;
  localparam logic [7:0] BREAK_BIT     = 8'h80;
  localparam logic [7:0] SHIFT_L_CODE  = 8'h12;
  localparam logic [7:0] SHIFT_R_CODE  = 8'h59;
  localparam logic [63:0] PAUSE_SEQ    = 64'h77f014f0e17714e1;
  localparam logic [3:0] PAUSE_LEN     = 4'h8;
  // arbitrary identification bytes
  localparam logic [7:0] ID_LOW        = 8'h5a;
  localparam logic [7:0] ID_HIGH       = 8'h3c;
  // option byte fields
  localparam int LED_W = 3;
  localparam int VAL_BIT7 = 7;
  localparam int RATE_W = 7;
  localparam logic [6:0] RATE_DEFAULT = 7'h2b;
  localparam logic [1:0] SET_QUERY = 2'h0;
  localparam logic [1:0] SET1 = 2'h1;
  localparam logic [1:0] SET2 = 2'h2;
  localparam logic [1:0] SET3 = 2'h3;
  localparam logic [1:0] SET_DEFAULT = 2'h2;
  // lockout exempt keys
  localparam int KEY_W = 7;
  localparam int EXEMPT_N = 7;
  localparam logic [6:0][6:0] LOCK_EXEMPT = {7'h68, 7'h67, 7'h65, 7'h64, 7'h5e, 7'h51, 7'h3c};
  // queue and sequences
  localparam int QPTR_W = 4;
  localparam logic [5:0] QDEPTH = 6'h10;
  localparam int SEQ_MAX = 8;
  // timing
  localparam int CLK_NS = 40;
  localparam int DELAY_UNIT_MS = 250;
  localparam int PERIOD_UNIT_NS = 4170000;
  localparam int POST_TIME_MS = 300;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000000 / CLK_NS;
  localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_NS / CLK_NS;
  localparam int POST_CYC = POST_TIME_MS * 1000000 / CLK_NS;
  localparam int PERIOD_BASE = 8;
  localparam int TMR_W = 26;
  localparam int POST_W = 24;
  // link frame
  localparam logic [3:0] RX_PARITY_BIT = 4'h8;
  localparam logic [3:0] RX_STOP_BIT = 4'h9;
  localparam logic [3:0] TX_FRAME_BITS = 4'hb;

  typedef enum logic [2:0] {ST_POST, ST_IDLE, ST_WAIT_LED, ST_WAIT_RATE, ST_WAIT_SET, ST_WAIT_KEY} kcr_cmd_st_t;
  typedef enum logic [1:0] {LK_IDLE, LK_RX, LK_ACK, LK_TX} kcr_link_st_t;
  typedef struct packed {
    logic [3:0]      len;
    logic [7:0][7:0] b;
  } kcr_seq_t;
endpackage

//--- rtl/kcr_link.sv
// serial frame engine on the link clock
`timescale 1ns/10ps
`default_nettype none
module kcr_link (
  input  wire logic       link_clk,
  input  wire logic       reset_n,
  input  wire logic       kbd_data_in,
  output logic            kbd_data_out,
  output logic            kbd_data_oe,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_req_tgl,
  output logic            tx_ack_tgl,
  output logic [7:0]      rx_byte,
  output logic            rx_perr,
  output logic            rx_tgl
);
  typedef struct packed {
    kcr_pkg::kcr_link_st_t mode;
    logic [3:0]            cnt;
    logic [10:0]           sh;
    logic [7:0]            rx_byte;
    logic                  rx_perr;
    logic                  rx_tgl;
    logic                  ack_tgl;
    logic                  req_s1;
    logic                  req_s2;
    logic                  drv_oe;
    logic                  drv_val;
  } kcr_link_state_t;

  kcr_link_state_t q;
  kcr_link_state_t n;

  always_comb
  begin
    n = q;
    n.req_s1 = tx_req_tgl;
    n.req_s2 = q.req_s1;
    case (q.mode)
      kcr_pkg::LK_IDLE:
      begin
        n.drv_oe = 1'b0;
        n.cnt = '0;
        if (!kbd_data_in)
          n.mode = kcr_pkg::LK_RX;
        else if (q.req_s2 != q.ack_tgl)
        begin
          n.mode = kcr_pkg::LK_TX;
          n.sh = {1'b1, ~^tx_byte, tx_byte, 1'b0};
        end
      end
      kcr_pkg::LK_RX:
      begin
        n.cnt = q.cnt + 4'h1;
        n.sh = {kbd_data_in, q.sh[10:1]};
        if (q.cnt == kcr_pkg::RX_STOP_BIT)
        begin
          n.sh = q.sh;
          n.rx_byte = q.sh[9:2];
          n.rx_perr = ~(^q.sh[10:2]) | ~kbd_data_in;
          n.rx_tgl = ~q.rx_tgl;
          n.drv_oe = kbd_data_in;
          n.drv_val = 1'b0;
          n.mode = kbd_data_in ? kcr_pkg::LK_ACK : kcr_pkg::LK_IDLE;
        end
      end
      kcr_pkg::LK_ACK:
      begin
        n.drv_oe = 1'b0;
        n.mode = kcr_pkg::LK_IDLE;
      end
      kcr_pkg::LK_TX:
      begin
        n.drv_oe = 1'b1;
        n.drv_val = q.sh[0];
        n.sh = {1'b1, q.sh[10:1]};
        n.cnt = q.cnt + 4'h1;
        if (q.cnt == kcr_pkg::TX_FRAME_BITS)
        begin
          n.drv_oe = 1'b0;
          n.ack_tgl = ~q.ack_tgl;
          n.mode = kcr_pkg::LK_IDLE;
        end
      end
      default: n.mode = kcr_pkg::LK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= n;
  end

  assign kbd_data_out = q.drv_val;
  assign kbd_data_oe  = q.drv_oe;
  assign tx_ack_tgl   = q.ack_tgl;
  assign rx_byte      = q.rx_byte;
  assign rx_perr      = q.rx_perr;
  assign rx_tgl       = q.rx_tgl;
endmodule // kcr_link
`default_nettype wire

//--- rtl/kcr_repeat_timer.sv
// autorepeat delay and period timer
`timescale 1ns/10ps
`default_nettype none
module kcr_repeat_timer #(
  parameter int unsigned DELAY_UNIT  = kcr_pkg::DELAY_UNIT_CYC,
  parameter int unsigned PERIOD_UNIT = kcr_pkg::PERIOD_UNIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [6:0] rate,
  output logic            fire
);
  typedef struct packed {
    logic                      run;
    logic                      fire;
    logic [kcr_pkg::TMR_W-1:0] cnt;
  } kcr_tmr_state_t;

  kcr_tmr_state_t q;
  kcr_tmr_state_t n;
  logic [31:0]    dly;
  logic [31:0]    per;

  always_comb
  begin
    dly = (32'(rate[6:5]) + 32'h1) * DELAY_UNIT;
    per = ((32'(kcr_pkg::PERIOD_BASE) + 32'(rate[2:0])) << rate[4:3]) * PERIOD_UNIT;
    n = q;
    n.fire = 1'b0;
    if (stop)
      n.run = 1'b0;
    else if (start)
    begin
      n.run = 1'b1;
      n.cnt = dly[kcr_pkg::TMR_W-1:0];
    end
    else if (q.run)
    begin
      if (q.cnt == '0)
      begin
        n.fire = 1'b1;
        n.cnt = per[kcr_pkg::TMR_W-1:0];
      end
      else
        n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= n;
  end

  assign fire = q.fire;
endmodule // kcr_repeat_timer
`default_nettype wire

//--- rtl/kcr_responder.sv
// keyboard command interpreter, response and scan byte queue
`timescale 1ns/10ps
`default_nettype none
module kcr_responder #(
  parameter int unsigned POST_CYC    = kcr_pkg::POST_CYC,
  parameter int unsigned DELAY_UNIT  = kcr_pkg::DELAY_UNIT_CYC,
  parameter int unsigned PERIOD_UNIT = kcr_pkg::PERIOD_UNIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  input  wire logic       kbd_data_in,
  output logic            kbd_data_out,
  output logic            kbd_data_oe,
  input  wire logic       post_ok,
  input  wire logic       key_valid,
  input  wire logic [6:0] key_num,
  input  wire logic [7:0] key_code,
  input  wire logic       key_make,
  input  wire logic       key_pause,
  input  wire logic       key_nav,
  input  wire logic       key_unknown,
  input  wire logic       shift_l_held,
  input  wire logic       shift_r_held,
  output logic            led_scroll,
  output logic            led_num,
  output logic            led_caps,
  output logic            scan_active,
  output logic [1:0]      scan_set,
  output logic [6:0]      rate_delay
);
  localparam logic [kcr_pkg::POST_W-1:0] POST_LAST = kcr_pkg::POST_W'(POST_CYC - 1);

  typedef struct packed {
    kcr_pkg::kcr_cmd_st_t           st;
    logic                           scan_en;
    logic [kcr_pkg::LED_W-1:0]      leds;
    logic [kcr_pkg::RATE_W-1:0]     rate;
    logic [1:0]                     sset;
    logic [2:0][7:0]                resp;
    logic [1:0]                     resp_n;
    logic [15:0][7:0]               mem;
    logic [kcr_pkg::QPTR_W-1:0]     head;
    logic [kcr_pkg::QPTR_W-1:0]     tail;
    logic [4:0]                     cnt;
    logic [7:0]                     last_tx;
    logic [7:0]                     tx_byte;
    logic                           tx_req;
    logic                           ack_s1;
    logic                           ack_s2;
    logic                           rx_s1;
    logic                           rx_s2;
    logic                           rx_s3;
    logic [1:0]                     slot_v;
    logic [1:0][kcr_pkg::KEY_W-1:0] slot;
    logic                           rep_v;
    logic [kcr_pkg::KEY_W-1:0]      rep_key;
    logic [7:0]                     rep_code;
    logic                           rep_nav;
    logic [kcr_pkg::POST_W-1:0]     post_cnt;
  } kcr_resp_state_t;

  kcr_resp_state_t   q;
  kcr_resp_state_t   n;
  kcr_pkg::kcr_seq_t seq;
  logic              push;
  logic              accept;
  logic              rx_new;
  logic              scanning;
  logic [5:0]        room;
  logic              tmr_start;
  logic              tmr_stop;
  logic              tmr_fire;
  logic              tx_ack_tgl;
  logic [7:0]        rx_byte;
  logic              rx_perr;
  logic              rx_tgl;

  function automatic logic is_exempt(input logic [6:0] k);
    logic r;
    r = 1'b0;
    for (int i = 0; i < kcr_pkg::EXEMPT_N; i++)
      if (k == kcr_pkg::LOCK_EXEMPT[i])
        r = 1'b1;
    return r;
  endfunction

  function automatic kcr_pkg::kcr_seq_t build_seq(input logic mk, input logic [7:0] code, input logic pause,
                                                  input logic nav, input logic shl, input logic shr,
                                                  input logic [1:0] sset);
    kcr_pkg::kcr_seq_t s;
    logic              wrap;
    s = '0;
    wrap = nav && (sset == kcr_pkg::SET2);
    if (pause && !mk)
      s.len = '0;
    else if (pause && sset == kcr_pkg::SET2)
    begin
      s.b = kcr_pkg::PAUSE_SEQ;
      s.len = kcr_pkg::PAUSE_LEN;
    end
    else if (sset == kcr_pkg::SET1)
    begin
      s.b[0] = mk ? code : (code | kcr_pkg::BREAK_BIT);
      s.len = 4'h1;
    end
    else if (mk)
    begin
      if (wrap && shl)
      begin
        s.b[s.len] = kcr_pkg::BREAK_PREFIX;
        s.b[s.len + 4'h1] = kcr_pkg::SHIFT_L_CODE;
        s.len = s.len + 4'h2;
      end
      if (wrap && shr)
      begin
        s.b[s.len] = kcr_pkg::BREAK_PREFIX;
        s.b[s.len + 4'h1] = kcr_pkg::SHIFT_R_CODE;
        s.len = s.len + 4'h2;
      end
      s.b[s.len] = code;
      s.len = s.len + 4'h1;
    end
    else
    begin
      s.b[0] = kcr_pkg::BREAK_PREFIX;
      s.b[1] = code;
      s.len = 4'h2;
      if (wrap && shl)
      begin
        s.b[s.len] = kcr_pkg::SHIFT_L_CODE;
        s.len = s.len + 4'h1;
      end
      if (wrap && shr)
      begin
        s.b[s.len] = kcr_pkg::SHIFT_R_CODE;
        s.len = s.len + 4'h1;
      end
    end
    return s;
  endfunction

  always_comb
  begin
    n = q;
    push = 1'b0;
    accept = 1'b0;
    seq = '0;
    room = '0;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    n.ack_s1 = tx_ack_tgl;
    n.ack_s2 = q.ack_s1;
    n.rx_s1 = rx_tgl;
    n.rx_s2 = q.rx_s1;
    n.rx_s3 = q.rx_s2;
    rx_new = q.rx_s2 ^ q.rx_s3;
    scanning = q.scan_en && (q.st == kcr_pkg::ST_IDLE);

    // transmit: answers first, then queued scan bytes
    if (q.tx_req == q.ack_s2)
    begin
      if (q.resp_n != 2'h0)
      begin
        n.tx_byte = q.resp[0];
        n.last_tx = q.resp[0];
        n.tx_req = ~q.tx_req;
        n.resp = {8'h00, q.resp[2:1]};
        n.resp_n = q.resp_n - 2'h1;
      end
      else if (scanning && q.cnt != 5'h0)
      begin
        n.tx_byte = q.mem[q.head];
        n.last_tx = q.mem[q.head];
        n.tx_req = ~q.tx_req;
        n.head = q.head + 1'b1;
        n.cnt = q.cnt - 5'h1;
      end
    end

    // key events and autorepeat
    if (scanning && key_valid)
    begin
      if (key_unknown)
      begin
        seq.b[0] = (q.sset == kcr_pkg::SET1) ? kcr_pkg::ERR_SET1 : kcr_pkg::ERR_SET23;
        seq.len = 4'h1;
        push = 1'b1;
      end
      else
      begin
        if (is_exempt(key_num))
          accept = 1'b1;
        else if (key_make)
        begin
          if ((q.slot_v[0] && q.slot[0] == key_num) || (q.slot_v[1] && q.slot[1] == key_num))
            accept = 1'b1;
          else if (!q.slot_v[0])
          begin
            accept = 1'b1;
            n.slot_v[0] = 1'b1;
            n.slot[0] = key_num;
          end
          else if (!q.slot_v[1])
          begin
            accept = 1'b1;
            n.slot_v[1] = 1'b1;
            n.slot[1] = key_num;
          end
        end
        else
        begin
          for (int i = 0; i < 2; i++)
            if (q.slot_v[i] && q.slot[i] == key_num)
            begin
              accept = 1'b1;
              n.slot_v[i] = 1'b0;
            end
        end
        if (accept)
        begin
          seq = build_seq(key_make, key_code, key_pause, key_nav, shift_l_held, shift_r_held, q.sset);
          push = 1'b1;
          if (key_make && !key_pause)
          begin
            n.rep_v = 1'b1;
            n.rep_key = key_num;
            n.rep_code = key_code;
            n.rep_nav = key_nav;
            tmr_start = 1'b1;
          end
          else if (!key_make && q.rep_v && q.rep_key == key_num)
          begin
            n.rep_v = 1'b0;
            tmr_stop = 1'b1;
          end
        end
      end
    end
    else if (scanning && tmr_fire && q.rep_v)
    begin
      seq = build_seq(1'b1, q.rep_code, 1'b0, q.rep_nav, shift_l_held, shift_r_held, q.sset);
      push = 1'b1;
    end

    if (push)
    begin
      room = 6'(n.cnt) + 6'(seq.len);
      if (room <= kcr_pkg::QDEPTH)
      begin
        for (int i = 0; i < kcr_pkg::SEQ_MAX; i++)
          if (4'(i) < seq.len)
            n.mem[n.tail + 4'(i)] = seq.b[i];
        n.tail = n.tail + seq.len;
        n.cnt = n.cnt + 5'(seq.len);
      end
      else if (n.cnt != 5'h0)
        n.mem[n.tail - 1'b1] = (q.sset == kcr_pkg::SET1) ? kcr_pkg::ERR_SET1 : kcr_pkg::ERR_SET23;
    end

    // self test after reset
    if (q.st == kcr_pkg::ST_POST)
    begin
      n.post_cnt = q.post_cnt + 1'b1;
      if (q.post_cnt == POST_LAST)
      begin
        n.resp[n.resp_n] = post_ok ? kcr_pkg::RSP_POST_OK : kcr_pkg::RSP_POST_FAIL;
        n.resp_n = n.resp_n + 2'h1;
        n.st = kcr_pkg::ST_IDLE;
        n.scan_en = 1'b1;
      end
    end
    else if (rx_new)
    begin
      n.resp[0] = kcr_pkg::RSP_ACK;
      n.resp_n = 2'h1;
      if (rx_perr)
        n.resp[0] = kcr_pkg::RSP_RESEND;
      else if (rx_byte >= kcr_pkg::CMD_SET_LEDS)
      begin
        n.st = kcr_pkg::ST_IDLE;
        case (rx_byte)
          kcr_pkg::CMD_SET_LEDS: n.st = kcr_pkg::ST_WAIT_LED;
          kcr_pkg::CMD_ECHO: n.resp[0] = kcr_pkg::RSP_ECHO;
          kcr_pkg::CMD_BAD_A, kcr_pkg::CMD_BAD_B: n.resp[0] = kcr_pkg::RSP_RESEND;
          kcr_pkg::CMD_SCAN_SET: n.st = kcr_pkg::ST_WAIT_SET;
          kcr_pkg::CMD_READ_ID:
          begin
            n.resp = {kcr_pkg::ID_HIGH, kcr_pkg::ID_LOW, kcr_pkg::RSP_ACK};
            n.resp_n = 2'h3;
            n.scan_en = 1'b1;
          end
          kcr_pkg::CMD_RATE: n.st = kcr_pkg::ST_WAIT_RATE;
          kcr_pkg::CMD_ENABLE: n.scan_en = 1'b1;
          kcr_pkg::CMD_DEF_DIS, kcr_pkg::CMD_SET_DEF:
          begin
            n.rate = kcr_pkg::RATE_DEFAULT;
            n.scan_en = (rx_byte == kcr_pkg::CMD_SET_DEF);
          end
          kcr_pkg::CMD_RESEND:
          begin
            n.resp[0] = q.last_tx;
            n.st = q.st;
          end
          kcr_pkg::CMD_RESET:
          begin
            n.st = kcr_pkg::ST_POST;
            n.post_cnt = '0;
            n.scan_en = 1'b0;
            n.leds = '0;
            n.rate = kcr_pkg::RATE_DEFAULT;
            n.sset = kcr_pkg::SET_DEFAULT;
          end
          default:
            if (rx_byte > kcr_pkg::CMD_ALL_LAST && rx_byte <= kcr_pkg::CMD_TYPE_LAST)
              n.st = kcr_pkg::ST_WAIT_KEY;
        endcase
        if (rx_byte != kcr_pkg::CMD_ECHO && rx_byte != kcr_pkg::CMD_RESEND &&
            rx_byte != kcr_pkg::CMD_BAD_A && rx_byte != kcr_pkg::CMD_BAD_B && rx_byte != kcr_pkg::CMD_SET_LEDS &&
            rx_byte != kcr_pkg::CMD_RATE && rx_byte != kcr_pkg::CMD_READ_ID)
        begin
          n.head = '0;
          n.tail = '0;
          n.cnt = '0;
          n.rep_v = 1'b0;
          tmr_stop = 1'b1;
        end
      end
      else
      begin
        n.st = kcr_pkg::ST_IDLE;
        case (q.st)
          kcr_pkg::ST_WAIT_LED: n.leds = rx_byte[kcr_pkg::LED_W-1:0];
          kcr_pkg::ST_WAIT_RATE:
            if (rx_byte[kcr_pkg::VAL_BIT7])
              n.resp[0] = kcr_pkg::RSP_RESEND;
            else
              n.rate = rx_byte[kcr_pkg::RATE_W-1:0];
          kcr_pkg::ST_WAIT_SET:
            if (rx_byte[1:0] == kcr_pkg::SET_QUERY && rx_byte[7:2] == 6'h00)
            begin
              n.resp[1] = {6'h00, q.sset};
              n.resp_n = 2'h2;
            end
            else if (rx_byte[7:2] == 6'h00)
              n.sset = rx_byte[1:0];
            else
              n.resp[0] = kcr_pkg::RSP_RESEND;
          kcr_pkg::ST_WAIT_KEY: n.st = kcr_pkg::ST_WAIT_KEY;
          default: n.resp[0] = kcr_pkg::RSP_RESEND;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= kcr_pkg::ST_POST;
      q.rate <= kcr_pkg::RATE_DEFAULT;
      q.sset <= kcr_pkg::SET_DEFAULT;
    end
    else
      q <= n;
  end

  kcr_repeat_timer #(
    .DELAY_UNIT  (DELAY_UNIT),
    .PERIOD_UNIT (PERIOD_UNIT)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (tmr_start),
    .stop    (tmr_stop),
    .rate    (q.rate),
    .fire    (tmr_fire)
  );

  kcr_link u_link (
    .link_clk     (link_clk),
    .reset_n      (reset_n),
    .kbd_data_in  (kbd_data_in),
    .kbd_data_out (kbd_data_out),
    .kbd_data_oe  (kbd_data_oe),
    .tx_byte      (q.tx_byte),
    .tx_req_tgl   (q.tx_req),
    .tx_ack_tgl   (tx_ack_tgl),
    .rx_byte      (rx_byte),
    .rx_perr      (rx_perr),
    .rx_tgl       (rx_tgl)
  );

  assign led_scroll  = q.leds[0];
  assign led_num     = q.leds[1];
  assign led_caps    = q.leds[2];
  assign scan_active = scanning;
  assign scan_set    = q.sset;
  assign rate_delay  = q.rate;
endmodule // kcr_responder
`default_nettype wire

//--- tb/kcr_responder_props.sv
// port checker for the keyboard command responder
`timescale 1ns/10ps
`default_nettype none
module kcr_props (
  input wire logic       ref_clk,
  input wire logic       link_clk,
  input wire logic       reset_n,
  input wire logic       kbd_data_out,
  input wire logic       kbd_data_oe,
  input wire logic       led_scroll,
  input wire logic       led_num,
  input wire logic       led_caps,
  input wire logic       scan_active,
  input wire logic [1:0] scan_set,
  input wire logic [6:0] rate_delay
);
  a_frame_start: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(kbd_data_oe) |-> !kbd_data_out)
    else $error("start bit high");
  a_frame_len: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(kbd_data_oe) ##1 kbd_data_oe |-> kbd_data_oe[*8] ##1 kbd_data_oe ##1 kbd_data_oe ##1 !kbd_data_oe)
    else $error("frame length wrong");
  a_stop_high: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(kbd_data_oe) && $past(kbd_data_oe, 2) |-> $past(kbd_data_out))
    else $error("stop bit low");
  a_line_free: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !kbd_data_oe)
    else $error("line driven after reset");
  a_lamps_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !led_caps && !led_num && !led_scroll)
    else $error("lamps lit after reset");
  a_rate_default: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> rate_delay == 7'h2b)
    else $error("rate not default");
  a_post_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !scan_active[*8])
    else $error("scanning during self test");
  a_set_valid: assert property (@(posedge ref_clk) disable iff (!reset_n)
    scan_set != 2'h0)
    else $error("scan set zero");
  c_frame: cover property (@(posedge link_clk) $rose(kbd_data_oe));
  c_caps: cover property (@(posedge ref_clk) $rose(led_caps));
  c_rate: cover property (@(posedge ref_clk) $changed(rate_delay));
endmodule // kcr_props
bind kcr_responder kcr_props u_props (.*);
`default_nettype wire

//--- tb/kcr_host_model.sv
// host controller model on the serial data line
`timescale 1ns/10ps
`default_nettype none
module kcr_host_model (
  input wire logic link_clk,
  input wire logic kbd_data_out,
  input wire logic kbd_data_oe,
  output logic     kbd_data_in
);
  logic h_low = 1'b0, busy = 1'b0;
  logic [3:0] n = 4'h0;
  logic [8:0] sh;
  logic [8:0] rx_q[$];
  // open-drain line with pull-up
  assign kbd_data_in = (kbd_data_oe ? kbd_data_out : 1'b1) & ~h_low;
  // start, data lsb first, odd parity, released stop
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    busy = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      @(negedge link_clk);
      h_low = ~f[i];
    end
    repeat (4) @(negedge link_clk);
    busy = 1'b0;
  endtask
  // device frames kept with their parity bit
  always @(posedge link_clk)
  begin
    if (n == 4'ha)
      rx_q.push_back(sh);
    sh <= {kbd_data_out, sh[8:1]};
    n <= n == 4'ha ? 4'h0 : n != 4'h0 ? n + 4'h1 : {3'h0, kbd_data_oe & ~kbd_data_out & ~busy};
  end
endmodule // kcr_host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the keyboard command responder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, post_ok = 1'b1, key_valid = 1'b0, key_make = 1'b0;
  logic key_pause = 1'b0, key_nav = 1'b0, key_unknown = 1'b0, shift_l_held = 1'b0, shift_r_held = 1'b0;
  logic [6:0] key_num = 7'h0;
  logic [7:0] key_code = 8'h0;
  logic kbd_data_in, kbd_data_out, kbd_data_oe, led_scroll, led_num, led_caps, scan_active;
  logic [1:0] scan_set;
  logic [6:0] rate_delay;
  time t0;
  int miscompares = 0, checked = 0;
  // host byte, reply, lamps, rate
  logic [31:0] rows[13] = '{32'hedfa002b, 32'h05fa052b, 32'hedfa052b, 32'hf3fa052b, 32'h20fa0520, 32'hf3fa0520,
    32'h85fe0520, 32'hf3fa0520, 32'heeee0520, 32'heffe0520, 32'hf6fa052b, 32'hf5fa052b, 32'hf4fa052b};
  // make flag, key number, code
  logic [15:0] keys[7] = '{16'h9e1c, 16'h9f1d, 16'ha82c, 16'hbc58, 16'h3c58, 16'h1e1c, 16'h1f1d};
  logic [7:0] kexp[9] = '{8'h1c, 8'h1d, 8'h58, 8'hf0, 8'h58, 8'hf0, 8'h1c, 8'hf0, 8'h1d};
  logic [7:0] nexp[7] = '{8'hf0, 8'h59, 8'h70, 8'hf0, 8'h70, 8'h59, 8'h00};
  logic [63:0] pause_seq = 64'he11477e1f014f077;
  kcr_responder #(.POST_CYC(50), .DELAY_UNIT(1000), .PERIOD_UNIT(100)) dut (.*);
  kcr_host_model host (.*);
  initial forever #20 ref_clk = ~ref_clk;
  initial #7 forever #80 link_clk = ~link_clk;
  task automatic test_done;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] e, input logic [9:0] s, input string w);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic rx(input logic [7:0] b);
    int k;
    for (k = 0; k < 5000 && host.rx_q.size() == 0; k++)
      @(negedge ref_clk);
    if (k == 5000)
    begin
      miscompares++;
      test_done();
    end
    else
      chk({~^b, b}, host.rx_q.pop_front(), "byte");
  endtask
  task automatic key(input logic [15:0] v);
    @(negedge ref_clk);
    {key_make, key_num, key_code} = v;
    key_valid = 1'b1;
    @(negedge ref_clk);
    key_valid = 1'b0;
  endtask
  initial
  begin
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    rx(8'haa);
    foreach (rows[i])
    begin
      host.send(rows[i][31:24], 1'b0);
      rx(rows[i][23:16]);
      chk({rows[i][10:8], rows[i][6:0]}, {led_caps, led_num, led_scroll, rate_delay}, "lamps rate");
    end
    host.send(8'hf2, 1'b0);
    rx(8'hfa);
    rx(kcr_pkg::ID_LOW);
    rx(kcr_pkg::ID_HIGH);
    host.send(8'hfe, 1'b0);
    rx(kcr_pkg::ID_HIGH);
    host.send(8'h00, 1'b1);
    rx(8'hfe);
    foreach (keys[i])
      key(keys[i]);
    foreach (kexp[i])
      rx(kexp[i]);
    host.send(8'hf3, 1'b0);
    rx(8'hfa);
    chk(10'h0, scan_active, "scan stop");
    host.send(8'h20, 1'b0);
    rx(8'hfa);
    key(16'h9e1c);
    rx(8'h1c);
    t0 = $time;
    rx(8'h1c);
    chk(10'h1, ($time - t0) / 40 - 1980 < 60, "delay");
    t0 = $time;
    rx(8'h1c);
    chk(10'h1, ($time - t0) / 40 - 780 < 60, "period");
    key(16'h1e1c);
    rx(8'hf0);
    rx(8'h1c);
    key_pause = 1'b1;
    repeat (3)
    begin
      key(16'h9077);
      key(16'h1077);
    end
    key_pause = 1'b0;
    for (int i = 0; i < 16; i++)
      rx(i == 15 ? 8'h00 : pause_seq[8 * (7 - i % 8) +: 8]);
    {key_nav, shift_r_held} = 2'h3;
    key(16'ha070);
    key(16'h2070);
    {key_nav, shift_r_held, key_unknown} = 3'h1;
    key(16'h0000);
    key_unknown = 1'b0;
    foreach (nexp[i])
      rx(nexp[i]);
    host.send(8'hf0, 1'b0);
    rx(8'hfa);
    host.send(8'h00, 1'b0);
    rx(8'hfa);
    rx(8'h02);
    host.send(8'hf0, 1'b0);
    rx(8'hfa);
    host.send(8'h01, 1'b0);
    rx(8'hfa);
    chk(10'h5, {scan_active, scan_set}, "scan set");
    key_unknown = 1'b1;
    key(16'h0000);
    key_unknown = 1'b0;
    key(16'h9e1c);
    key(16'h1e1c);
    rx(8'hff);
    rx(8'h1c);
    rx(8'h9c);
    reset_n = 1'b0;
    post_ok = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    rx(8'hfc);
    chk(10'h2b, {led_caps, led_num, led_scroll, rate_delay}, "defaults");
    chk(10'h6, {scan_active, scan_set}, "scan default");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
